// ### common/acfg_cfg.svh
// register offsets, field positions and reset values for the channel trim bank
`ifndef ACFG_CFG_SVH
`define ACFG_CFG_SVH
`define ACFG_OFS_CH2_GAIN_TRIM 8'h44
`define ACFG_OFS_CH2_PHASE_DELAY 8'h45
`define ACFG_OFS_CH3_INPUT_CONFIG 8'h46
`define ACFG_OFS_CH3_ANALOG_GAIN_CONFIG 8'h47
`define ACFG_RST_CH2_GAIN_TRIM 8'h80
`define ACFG_RST_CH2_PHASE_DELAY 8'h00
`define ACFG_RST_CH3_INPUT_CONFIG 8'h00
`define ACFG_RST_CH3_ANALOG_GAIN_CONFIG 8'h00
`define ACFG_MASK_CH2_GAIN_TRIM 8'hF0
`define ACFG_MASK_CH2_PHASE_DELAY 8'hFF
`define ACFG_MASK_CH3_INPUT_CONFIG 8'hFD
`define ACFG_MASK_CH3_ANALOG_GAIN_CONFIG 8'hFC
`define ACFG_GTRIM_LSB 4
`define ACFG_LINE_BIT 7
`define ACFG_SRC_LSB 5
`define ACFG_DC_BIT 4
`define ACFG_IMP_LSB 2
`define ACFG_AGC_BIT 0
`define ACFG_GAIN_LSB 2
`define ACFG_GAIN_MAX 6'h2A
`define ACFG_AGC_GLOBAL_BIT 3
`endif

// ### common/acfg_pkg.sv
// types shared by the channel trim register bank
package acfg_pkg;
  typedef enum logic [1:0] {
    ACFG_SRC_ANA_DIFF = 2'h0,
    ACFG_SRC_ANA_SE = 2'h1,
    ACFG_SRC_PDM = 2'h2,
    ACFG_SRC_RSVD = 2'h3
  } acfg_src_t;
  typedef enum logic [1:0] {
    ACFG_IMP_2K5 = 2'h0,
    ACFG_IMP_10K = 2'h1,
    ACFG_IMP_20K = 2'h2,
    ACFG_IMP_RSVD = 2'h3
  } acfg_imp_t;
  typedef struct packed {
    logic line_select;
    acfg_src_t source;
    logic dc_coupled;
    acfg_imp_t impedance;
    logic auto_gain_on;
    logic analog_sel;
    logic pdm_sel;
    logic [5:0] analog_gain;
    logic gain_valid;
  } acfg_ch3_t;
  typedef struct packed {
    logic [3:0] gain_trim_code;
    logic [7:0] phase_delay_cycles;
  } acfg_ch2_t;
endpackage

// ### hdl/acfg_regs.sv
// channel 2 trim and channel 3 input configuration registers behind apb
// What this block does
// - ch2 gain trim bits 7:4 reset 8 (0 dB), 0.1 dB steps, -0.8..+0.7 dB.
// - ch2 phase trim 8 bits, reset 0, delays N modulator clock cycles.
// - ch3 bit 7 selects mic (0) or line (1) input, reset 0.
// - ch3 bits 6:5 source: differential, single-ended, pdm mic; 3 reserved.
// - source 2 takes ch3 from second pdm data input with pdm clock.
// - ch3 bit 4 coupling: 0 ac, 1 dc, analog only, reset ac.
// - ch3 bits 3:2 impedance 2.5k, 10k, 20k; code 3 reserved.
// - ch3 bit 0 enables agc, qualified by global agc config bit 3.
// - page 0 bytes 0x44..0x47 in order; gain trim resets 0x80, others zero. The code decodes them as word indices, at bytes 0x110..0x11C.
// - ch3_analog_gain bits 7:2, 1 dB steps 0..42 dB; 43..63 reserved.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "acfg_cfg.svh"
module acfg_regs
  import acfg_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // global agc configuration from register 108 of page 0
  input wire logic [7:0] agc_global_config,
  // pdm path for channel 3
  input wire logic pdm_data_in_two,
  input wire logic pdm_clock_out,
  // configuration outputs
  output acfg_ch2_t ch2_cfg,
  output acfg_ch3_t ch3_cfg,
  output logic ch3_agc_active,
  output logic ch3_pdm_sample
);

  localparam int NREG = 4;
  localparam logic [7:0] OFS [NREG] = '{`ACFG_OFS_CH2_GAIN_TRIM, `ACFG_OFS_CH2_PHASE_DELAY,
    `ACFG_OFS_CH3_INPUT_CONFIG, `ACFG_OFS_CH3_ANALOG_GAIN_CONFIG};
  localparam logic [7:0] RST [NREG] = '{`ACFG_RST_CH2_GAIN_TRIM, `ACFG_RST_CH2_PHASE_DELAY,
    `ACFG_RST_CH3_INPUT_CONFIG, `ACFG_RST_CH3_ANALOG_GAIN_CONFIG};
  localparam logic [7:0] MSK [NREG] = '{`ACFG_MASK_CH2_GAIN_TRIM, `ACFG_MASK_CH2_PHASE_DELAY,
    `ACFG_MASK_CH3_INPUT_CONFIG, `ACFG_MASK_CH3_ANALOG_GAIN_CONFIG};

  logic [7:0] regs [NREG];
  logic [NREG-1:0] hit;
  logic [7:0] rd_byte;
  logic pdm_clock_d;
  logic ch3_pdm_bit;

  // single-cycle access phase: no wait states
  wire access = psel && penable;
  wire wr_en = access && pwrite && pstrb[0];
  // printed offsets are word indices: the byte address is four times the index
  wire word_aligned = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0);
  wire mapped = |hit;

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      assign hit[gi] = word_aligned && (paddr[9:2] == OFS[gi]);
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          regs[gi] <= RST[gi];
        end else if (wr_en && hit[gi]) begin
          regs[gi] <= pwdata[7:0] & MSK[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        rd_byte = regs[i] & MSK[i];
      end
    end
  end

  assign pready = 1'b1;
  // unmapped or misaligned addresses answer with an error, reads return zero
  assign pslverr = access && !mapped;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h0, rd_byte};
    end
  end

  // channel 2 fields
  assign ch2_cfg.gain_trim_code = regs[0][`ACFG_GTRIM_LSB +: 4];
  assign ch2_cfg.phase_delay_cycles = regs[1];

  // channel 3 input fields
  wire [7:0] icfg = regs[2];
  wire [1:0] src_code = icfg[`ACFG_SRC_LSB +: 2];
  wire is_analog = (src_code == ACFG_SRC_ANA_DIFF) || (src_code == ACFG_SRC_ANA_SE);
  wire is_pdm = (src_code == ACFG_SRC_PDM);
  wire [5:0] gain_code = regs[3][`ACFG_GAIN_LSB +: 6];

  assign ch3_cfg.line_select = icfg[`ACFG_LINE_BIT];
  assign ch3_cfg.source = acfg_src_t'(src_code);
  // coupling only matters to the analog front end; impedance passes through for every source
  assign ch3_cfg.dc_coupled = icfg[`ACFG_DC_BIT] && is_analog;
  assign ch3_cfg.impedance = acfg_imp_t'(icfg[`ACFG_IMP_LSB +: 2]);
  assign ch3_cfg.auto_gain_on = icfg[`ACFG_AGC_BIT];
  assign ch3_cfg.analog_sel = is_analog;
  assign ch3_cfg.pdm_sel = is_pdm;
  assign ch3_cfg.analog_gain = gain_code;
  // reserved gain codes are stored but flagged so the gain stage can ignore them
  assign ch3_cfg.gain_valid = (gain_code <= `ACFG_GAIN_MAX);

  assign ch3_agc_active = icfg[`ACFG_AGC_BIT] && agc_global_config[`ACFG_AGC_GLOBAL_BIT];

  // pdm data is taken on the rising edge of the pdm clock while source is pdm
  wire pdm_rise = pdm_clock_out && !pdm_clock_d;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pdm_clock_d <= 1'b0;
    end else begin
      pdm_clock_d <= pdm_clock_out;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ch3_pdm_bit <= 1'b0;
    end else if (is_pdm && pdm_rise) begin
      ch3_pdm_bit <= pdm_data_in_two;
    end
  end

  assign ch3_pdm_sample = ch3_pdm_bit;

endmodule // acfg_regs

// ### verif/acfg_regs_asserts.sv
// port assertions for the channel trim register bank
`timescale 1ns/1ps
module acfg_regs_asserts
  import acfg_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // watched ports
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] agc_global_config,
  input wire acfg_ch2_t ch2_cfg,
  input wire acfg_ch3_t ch3_cfg,
  input wire logic ch3_agc_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence acc_s;
    psel && penable;
  endsequence
  chk_zero_wait: assert property (acc_s |-> pready)
    else $error("access not ready");
  // word index times four, so the bank spans 0x110 to 0x11C
  chk_map_ok: assert property (acc_s |-> pslverr == (paddr[31:4] != 28'h11 || paddr[1:0] != 0))
    else $error("bad decode response");
  chk_cfg_hold: assert property (!(psel && penable) |=> $stable(ch2_cfg))
    else $error("trim moved without access");
  chk_agc_gate: assert property (ch3_agc_active == (ch3_cfg.auto_gain_on && agc_global_config[3]))
    else $error("agc gate wrong");
  chk_pdm_sel: assert property (ch3_cfg.pdm_sel == (ch3_cfg.source == ACFG_SRC_PDM))
    else $error("pdm select wrong");
  chk_ana_sel: assert property (ch3_cfg.analog_sel == (ch3_cfg.source < 2'h2))
    else $error("analog select wrong");
  chk_dc_analog: assert property (ch3_cfg.dc_coupled |-> ch3_cfg.analog_sel)
    else $error("dc on non analog source");
  chk_gain_range: assert property (ch3_cfg.gain_valid == (ch3_cfg.analog_gain <= 6'h2A))
    else $error("gain range flag wrong");
endmodule // acfg_regs_asserts
bind acfg_regs acfg_regs_asserts u_chk (.clock, .nrst, .psel, .penable, .paddr, .pready,
  .pslverr, .agc_global_config, .ch2_cfg, .ch3_cfg, .ch3_agc_active);

// ### verif/tb.sv
// self-checking bench for the channel trim register bank
`timescale 1ns/1ps
module tb;
  import acfg_pkg::*;
  logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic pdm_data_in_two = 0, pdm_clock_out = 0, pready, pslverr, ch3_agc_active, ch3_pdm_sample;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [7:0] agc_global_config = 0;
  acfg_ch2_t ch2_cfg;
  acfg_ch3_t ch3_cfg;
  int error_cnt = 0, compares = 0, cyc = 0;
  localparam logic [7:0] IDX [4] = '{8'h44, 8'h45, 8'h46, 8'h47};
  localparam logic [7:0] MSK [4] = '{8'hF0, 8'hFF, 8'hFD, 8'hFC};
  acfg_regs i_dut (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .agc_global_config, .pdm_data_in_two, .pdm_clock_out,
    .ch2_cfg, .ch3_cfg, .ch3_agc_active, .ch3_pdm_sample);
  initial forever #5 clock = ~clock;
  // the whole run needs well under a thousand cycles
  always @(posedge clock) if (++cyc > 3000) begin
    error_cnt++;
    wrap_up();
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] idx, logic [7:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clock) penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1;
    @(posedge clock);
    foreach (IDX[i]) begin
      apb(0, IDX[i], 0);
      chk("reset", i ? 0 : 8'h80, rd);
      apb(1, IDX[i], 8'hFF);
      apb(0, IDX[i], 0);
      chk("mask", MSK[i], rd);
    end
    chk("ch2", 12'hFFF, ch2_cfg);
    $display("register test done");
    agc_global_config <= 8'h08;
    for (int s = 0; s < 4; s++) begin
      apb(1, 8'h46, {1'b1, 2'(s), 1'b1, 2'(s), 2'h1});
      chk("ch3", {1'b1, 2'(s), 2'(s), s < 2, s == 2, s < 2}, {ch3_cfg.line_select,
        ch3_cfg.source, ch3_cfg.impedance, ch3_cfg.dc_coupled, ch3_cfg.pdm_sel,
        ch3_cfg.analog_sel});
      chk("agc", 1, ch3_agc_active);
      if (s == 2) begin
        pdm_data_in_two <= 1;
        @(posedge clock) pdm_clock_out <= 1;
        repeat (2) @(posedge clock);
        chk("pdm", 1, ch3_pdm_sample);
        pdm_clock_out <= 0;
      end
    end
    agc_global_config <= 8'h00;
    @(posedge clock);
    chk("agc off", 0, ch3_agc_active);
    $display("channel 3 test done");
    apb(1, 8'h47, 8'hA8);
    chk("gain 42", 7'h55, {ch3_cfg.analog_gain, ch3_cfg.gain_valid});
    apb(1, 8'h47, 8'hAC);
    chk("gain 43", 7'h56, {ch3_cfg.analog_gain, ch3_cfg.gain_valid});
    apb(0, 8'h48, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    $display("gain and decode test done");
    wrap_up();
  end
endmodule // tb
